// *** rtl/irq_status_and_wan_priority.sv ***
// interrupt status low bits and WAN MAC priority arbitration, APB slave
// assumes all inputs synchronous to clock; one wait state on every access
//
// Overview of operation
// - the timer 0 flag at bit 6 sets when the timer 0 event rises.
// - the timer 0 flag holds until software writes one to it.
// - ext pin flags 3..0 sit at bits 5..2 and set on their pin.
// - in edge mode an ext pin flag holds until software writes one.
// - bit 1 mirrors the debug channel transmit-empty indication.
// - bit 0 mirrors the debug channel receive-full indication.
// - both debug channel bits are level bits that writes cannot touch.
// - a priority field is one of 16 levels, 0xF highest, 0x0 lowest.
// - a pending fast request beats every normal request.
// - the WAN priority register holds seven 4-bit fields in 27..0.
// - a WAN source only competes while it is enabled.
`include "irq_wan_params.svh"
module irq_status_and_wan_priority (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_r,
  output logic pready_r,
  output logic pslverr_r,
  input wire logic timer0_event,
  input wire logic [3:0] ext_pin,
  input wire logic dbg_tx_empty,
  input wire logic dbg_rx_full,
  input wire logic fast_req,
  input wire logic [6:0] wan_req,
  output logic irq_r,
  output irq_wan_pkg::arb_type arb_state_r,
  output logic [2:0] win_src_r,
  output logic [3:0] win_level_r
);
  import irq_wan_pkg::*;

  logic [`STAT_W-1:0] stat_r;
  logic [`STAT_W-1:0] raw_d_r;
  logic [`STAT_W-1:0] raw;
  logic [`STAT_W-1:0] rise;
  logic [`STAT_W-1:0] evt_r;
  logic [`STAT_W-1:0] mask_r;
  logic [`PRIO_W-1:0] prio_r;
  logic [3:0] trig_edge_r;
  logic [6:0] wan_en_r;
  logic done;
  logic wr;
  logic rd;
  logic wr_stat;
  logic found;
  logic [2:0] best_src;
  logic [3:0] best_lvl;

  // address compare, used by every decoder
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction : hit

  // read data for an address, zero elsewhere
  function automatic logic [31:0] rd_mux(input logic [15:0] a,
      input logic [6:0] st, input logic [27:0] pr, input logic [3:0] tg,
      input logic [6:0] en, input logic [6:0] ev, input logic [6:0] mk,
      input logic [2:0] ar, input logic [2:0] ws, input logic [3:0] wl);
    rd_mux = 32'h00000000;
    if (hit(a, `STATUS_ADDR)) rd_mux = {25'h0000000, st};
    if (hit(a, `PRIO_ADDR)) rd_mux = {4'h0, pr};
    if (hit(a, `TRIG_ADDR)) rd_mux = {28'h0000000, tg};
    if (hit(a, `WAN_EN_ADDR)) rd_mux = {25'h0000000, en};
    if (hit(a, `EVENT_ADDR)) rd_mux = {25'h0000000, ev};
    if (hit(a, `MASK_ADDR)) rd_mux = {25'h0000000, mk};
    if (hit(a, `ARB_ADDR)) rd_mux = {22'h000000, ar, ws, wl};
  endfunction : rd_mux

  function automatic logic mapped(input logic [15:0] a);
    mapped = hit(a, `STATUS_ADDR) | hit(a, `PRIO_ADDR) | hit(a, `TRIG_ADDR)
      | hit(a, `WAN_EN_ADDR) | hit(a, `EVENT_ADDR) | hit(a, `MASK_ADDR)
      | hit(a, `ARB_ADDR);
  endfunction : mapped

  // transfer completes at the edge where pready is sampled high
  assign done = psel & penable & pready_r;
  assign wr = done & pwrite;
  assign rd = done & ~pwrite;
  assign wr_stat = wr & hit(paddr, `STATUS_ADDR);

  // apb answer: one wait state, read data and error registered
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (psel && penable && !pready_r) begin
      pready_r <= 1'b1;
      pslverr_r <= ~mapped(paddr);
      prdata_r <= pwrite ? 32'h00000000 : rd_mux(paddr, stat_r, prio_r,
        trig_edge_r, wan_en_r, evt_r, mask_r, arb_state_r, win_src_r,
        win_level_r);
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // writable control registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prio_r <= `PRIO_RST;
      trig_edge_r <= `TRIG_RST;
      wan_en_r <= `WAN_EN_RST;
      mask_r <= `MASK_RST;
    end else if (wr) begin
      if (hit(paddr, `PRIO_ADDR)) prio_r <= pwdata[27:0];
      if (hit(paddr, `TRIG_ADDR)) trig_edge_r <= pwdata[3:0];
      if (hit(paddr, `WAN_EN_ADDR)) wan_en_r <= pwdata[6:0];
      if (hit(paddr, `MASK_ADDR)) mask_r <= pwdata[6:0];
    end
  end

  // source history for rising-edge detection
  assign raw = {timer0_event, ext_pin, dbg_tx_empty, dbg_rx_full};
  assign rise = raw & ~raw_d_r;
  always_ff @(posedge clock) begin
    if (!rst_n) raw_d_r <= `STAT_RST;
    else raw_d_r <= raw;
  end

  // timer 0 flag: edge latched, write one clears, set wins
  always_ff @(posedge clock) begin
    if (!rst_n) stat_r[`TIMER0_BIT] <= 1'b0;
    else if (rise[`TIMER0_BIT]) stat_r[`TIMER0_BIT] <= 1'b1;
    else if (wr_stat && pwdata[`TIMER0_BIT])
      stat_r[`TIMER0_BIT] <= 1'b0;
  end

  // external pin flags, edge or level per pin
  for (genvar i = 0; i < 4; i++) begin : g_ext
    always_ff @(posedge clock) begin
      if (!rst_n) stat_r[`EXT_LSB+i] <= 1'b0;
      else if (!trig_edge_r[i])
        stat_r[`EXT_LSB+i] <= ext_pin[i];
      else if (rise[`EXT_LSB+i])
        stat_r[`EXT_LSB+i] <= 1'b1;
      else if (wr_stat && pwdata[`EXT_LSB+i])
        stat_r[`EXT_LSB+i] <= 1'b0;
    end
  end

  // debug channel flags follow their sources, ignore writes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stat_r[`DBG_TX_BIT] <= 1'b0;
      stat_r[`DBG_RX_BIT] <= 1'b0;
    end else begin
      stat_r[`DBG_TX_BIT] <= dbg_tx_empty;
      stat_r[`DBG_RX_BIT] <= dbg_rx_full;
    end
  end

  // sticky events; a read clears only the bits it returned, new edges win
  always_ff @(posedge clock) begin
    if (!rst_n) evt_r <= `STAT_RST;
    else if (rd && hit(paddr, `EVENT_ADDR))
      evt_r <= (evt_r & ~prdata_r[`STAT_W-1:0]) | rise;
    else evt_r <= evt_r | rise;
  end

  // level interrupt output
  always_ff @(posedge clock) begin
    if (!rst_n) irq_r <= 1'b0;
    else irq_r <= |(evt_r & mask_r);
  end

  // highest level among enabled pending sources; ties go to transmit side
  always_comb begin
    found = 1'b0;
    best_src = 3'h0;
    best_lvl = `LEVEL_MIN;
    for (int j = `PRIO_FIELDS - 1; j >= 0; j--) begin
      if (wan_req[j] && wan_en_r[j] &&
          (!found || prio_r[j*4 +: 4] > best_lvl)) begin
        found = 1'b1;
        best_src = 3'(j);
        best_lvl = prio_r[j*4 +: 4];
      end
    end
  end

  // registered arbitration outcome, fast request first
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      arb_state_r <= ARB_NONE;
      win_src_r <= 3'h0;
      win_level_r <= `LEVEL_MIN;
    end else begin
      win_src_r <= best_src;
      win_level_r <= best_lvl;
      case ({fast_req, found})
        2'b10, 2'b11: arb_state_r <= ARB_FAST;
        2'b01: arb_state_r <= ARB_NORMAL;
        default: arb_state_r <= ARB_NONE;
      endcase
    end
  end

  // helper: eligible set one cycle back, only checks read it
  logic [6:0] elig_d_r;
  always_ff @(posedge clock) begin
    if (!rst_n) elig_d_r <= 7'h00;
    else elig_d_r <= wan_req & wan_en_r;
  end

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait_then_ready;
    (psel && penable && !pready_r) ##1 pready_r;
  endsequence

  // bus answer timing and error response
  a_apb_answer: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_setup ##1 psel |-> s_wait_then_ready)
    else $error("apb answer not after one wait state");
  a_slverr_unmapped: assert property (
    @(posedge clock) disable iff (!rst_n)
    done |-> pslverr_r == !mapped(paddr))
    else $error("error response does not match address map");
  // timer 0 flag
  a_timer_set: assert property (
    @(posedge clock) disable iff (!rst_n)
    timer0_event && !$past(timer0_event) |=> stat_r[`TIMER0_BIT])
    else $error("timer flag did not set");
  a_timer_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    stat_r[`TIMER0_BIT] && !(wr_stat && pwdata[`TIMER0_BIT])
    |=> stat_r[`TIMER0_BIT])
    else $error("timer flag lost without write");
  a_timer_clear: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_stat && pwdata[`TIMER0_BIT] && !rise[`TIMER0_BIT]
    |=> !stat_r[`TIMER0_BIT])
    else $error("timer flag not cleared by write one");
  // external pin flags
  a_ext_edge_latch: assert property (
    @(posedge clock) disable iff (!rst_n)
    trig_edge_r[0] && rise[`EXT_LSB] |=> stat_r[`EXT_LSB])
    else $error("ext pin 0 edge not latched");
  a_ext_edge_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    trig_edge_r[0] && stat_r[`EXT_LSB] && !(wr_stat && pwdata[`EXT_LSB])
    |=> stat_r[`EXT_LSB])
    else $error("ext pin 0 edge flag dropped");
  a_ext_edge_clear: assert property (
    @(posedge clock) disable iff (!rst_n)
    trig_edge_r[0] && wr_stat && pwdata[`EXT_LSB] && !rise[`EXT_LSB]
    |=> !stat_r[`EXT_LSB])
    else $error("ext pin 0 edge flag not cleared by write one");
  a_ext_level: assert property (
    @(posedge clock) disable iff (!rst_n)
    !trig_edge_r[1] |=> stat_r[`EXT_LSB+1] == $past(ext_pin[1]))
    else $error("ext pin 1 level flag not following pin");
  // debug channel flags
  a_dbg_tx: assert property (
    @(posedge clock) disable iff (!rst_n)
    ##1 stat_r[`DBG_TX_BIT] == $past(dbg_tx_empty))
    else $error("tx empty flag mismatch");
  a_dbg_rx: assert property (
    @(posedge clock) disable iff (!rst_n)
    ##1 stat_r[`DBG_RX_BIT] == $past(dbg_rx_full))
    else $error("rx full flag mismatch");
  a_dbg_nowrite: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_stat && !dbg_rx_full |=> !stat_r[`DBG_RX_BIT])
    else $error("write affected rx flag");
  // event bits and the interrupt line
  a_evt_sticky: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(rd && hit(paddr, `EVENT_ADDR)) |=> (evt_r & $past(evt_r)) == $past(evt_r))
    else $error("event bit dropped without a read");
  a_evt_no_loss: assert property (
    @(posedge clock) disable iff (!rst_n)
    rd && hit(paddr, `EVENT_ADDR) |=>
    (($past(evt_r) & ~$past(prdata_r[`STAT_W-1:0]) & ~evt_r) == 7'h00))
    else $error("event lost across a clearing read");
  a_irq_level: assert property (
    @(posedge clock) disable iff (!rst_n)
    ##1 irq_r == (|$past(evt_r & mask_r)))
    else $error("interrupt line does not follow masked events");
  // priority register and arbitration
  a_prio_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr && hit(paddr, `PRIO_ADDR) |=> prio_r == $past(pwdata[27:0]))
    else $error("priority write not stored");
  a_prio_top_zero: assert property (
    @(posedge clock) disable iff (!rst_n)
    done && !pwrite && hit(paddr, `PRIO_ADDR) |-> prdata_r[31:28] == 4'h0)
    else $error("reserved priority bits read nonzero");
  a_fast_first: assert property (
    @(posedge clock) disable iff (!rst_n)
    fast_req |=> arb_state_r == ARB_FAST)
    else $error("fast request not first");
  a_win_enabled: assert property (
    @(posedge clock) disable iff (!rst_n)
    arb_state_r == ARB_NORMAL |-> elig_d_r[win_src_r])
    else $error("disabled source won");
  a_arb_none: assert property (
    @(posedge clock) disable iff (!rst_n)
    !fast_req && (wan_req & wan_en_r) == 7'h00 |=> arb_state_r == ARB_NONE)
    else $error("arbitration outcome without eligible request");
  a_win_highest: assert property (
    @(posedge clock) disable iff (!rst_n)
    ##1 (arb_state_r == ARB_NORMAL && elig_d_r[6])
    |-> win_level_r >= $past(prio_r[27:24]))
    else $error("winner below transmit level");
endmodule : irq_status_and_wan_priority

// *** rtl/irq_wan_params.svh ***
// offsets, field positions, reset values of the status and priority block
// assumes a 16-bit APB byte address and 32-bit data words
`ifndef IRQ_WAN_PARAMS_SVH
`define IRQ_WAN_PARAMS_SVH
// register byte addresses
`define STATUS_ADDR 16'hE210
`define PRIO_ADDR 16'hE218
`define TRIG_ADDR 16'hE240
`define WAN_EN_ADDR 16'hE244
`define EVENT_ADDR 16'hE248
`define MASK_ADDR 16'hE24C
`define ARB_ADDR 16'hE250
// status bit positions
`define TIMER0_BIT 6
`define EXT_LSB 2
`define DBG_TX_BIT 1
`define DBG_RX_BIT 0
`define STAT_W 7
// priority register layout: seven 4-bit fields in bits 27..0
`define PRIO_W 28
`define PRIO_FIELDS 7
`define LEVEL_W 4
`define LEVEL_MAX 4'hF
`define LEVEL_MIN 4'h0
// reset values
`define PRIO_RST 28'h0000000
`define STAT_RST 7'h00
`define TRIG_RST 4'h0
`define WAN_EN_RST 7'h00
`define MASK_RST 7'h00
`endif

// *** rtl/irq_wan_pkg.sv ***
// types shared by the status and priority block
// assumes nothing beyond a SystemVerilog compiler
package irq_wan_pkg;
  // arbitration outcome, one-hot
  typedef enum logic [2:0] {
    ARB_NONE = 3'b001,
    ARB_FAST = 3'b010,
    ARB_NORMAL = 3'b100
  } arb_type;
endpackage : irq_wan_pkg

// *** testbench/irq_src_model.sv ***
// model of the peripheral interrupt sources and the debug channel
// assumes the bench hands it a packed level vector, taken each clock
module irq_src_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [14:0] src,
  output logic timer0_event,
  output logic [3:0] ext_pin,
  output logic dbg_tx_empty,
  output logic dbg_rx_full,
  output logic fast_req,
  output logic [6:0] wan_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [14:0] lv_r;
  // levels change just after an edge and stay quiet in reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lv_r <= 15'h0000;
    end else begin
      lv_r <= src;
    end
  end
  // timer, pins, debug channel, fast request, wan sources
  assign {timer0_event, ext_pin, dbg_tx_empty, dbg_rx_full} = lv_r[14:8];
  assign {fast_req, wan_req} = lv_r[7:0];
endmodule : irq_src_model

// *** testbench/tb_irq_status_and_wan_priority.sv ***
// bench for the status and wan priority block, apb tasks and checks
// assumes the design package, params header and source model
`include "irq_wan_params.svh"
module tb_irq_status_and_wan_priority;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_wan_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata_r, rd, ex;
  logic pready_r, pslverr_r, irq_r, er;
  logic timer0_event, dbg_tx_empty, dbg_rx_full, fast_req;
  logic [3:0] ext_pin, win_level_r;
  logic [6:0] wan_req;
  logic [2:0] win_src_r;
  arb_type arb_state_r;
  logic [14:0] src = 15'h0000;
  int failures = 0, n_tests = 0;
  always #2 clock = ~clock;
  irq_status_and_wan_priority i_irq_status_and_wan_priority (.clock,
    .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_r,
    .pready_r, .pslverr_r, .timer0_event, .ext_pin, .dbg_tx_empty,
    .dbg_rx_full, .fast_req, .wan_req, .irq_r, .arb_state_r, .win_src_r,
    .win_level_r);
  irq_src_model i_src (.clock, .rst_n, .src, .timer0_event, .ext_pin,
    .dbg_tx_empty, .dbg_rx_full, .fast_req, .wan_req);
  // compare one word
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // compare the arbitration outputs as one group
  task chk_arb(input arb_type a, input logic [2:0] s, input logic [3:0] l);
    chk({22'h0, arb_state_r, win_src_r, win_level_r}, {22'h0, a, s, l});
  endtask : chk_arb
  // one apb transfer, held until pready is seen at an edge
  task xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready_r !== 1'b1) @(posedge clock);
    rd = prdata_r;
    er = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task rdc(input logic [15:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  // new source levels, then let them pass model and flag registers
  task put(input logic [14:0] s);
    src <= s;
    repeat (3) @(posedge clock);
  endtask : put
  task close_out;
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // hang guard, far beyond the 40 transfers below
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    close_out;
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rdc(`PRIO_ADDR, 32'h0);
    rdc(`STATUS_ADDR, 32'h0);
    xfer(1'b1, `PRIO_ADDR, 32'hFFFFFFFF);
    rdc(`PRIO_ADDR, 32'h0FFFFFFF);
    put(15'h4000);
    put(15'h0000);
    rdc(`STATUS_ADDR, 32'h40);
    xfer(1'b1, `STATUS_ADDR, 32'h3F);
    rdc(`STATUS_ADDR, 32'h40);
    xfer(1'b1, `STATUS_ADDR, 32'h40);
    rdc(`STATUS_ADDR, 32'h0);
    put(15'h3C00);
    rdc(`STATUS_ADDR, 32'h3C);
    xfer(1'b1, `STATUS_ADDR, 32'h3C);
    rdc(`STATUS_ADDR, 32'h3C);
    put(15'h0000);
    rdc(`STATUS_ADDR, 32'h0);
    xfer(1'b1, `TRIG_ADDR, 32'hF);
    rdc(`TRIG_ADDR, 32'hF);
    ex = 32'h0;
    for (int i = 0; i < 4; i++) begin
      put(15'h0400 << i);
      put(15'h0000);
      ex = ex | (32'h4 << i);
      rdc(`STATUS_ADDR, ex);
    end
    xfer(1'b1, `STATUS_ADDR, 32'h14);
    rdc(`STATUS_ADDR, 32'h28);
    xfer(1'b1, `STATUS_ADDR, 32'h28);
    rdc(`STATUS_ADDR, 32'h0);
    put(15'h0300);
    rdc(`STATUS_ADDR, 32'h3);
    xfer(1'b1, `STATUS_ADDR, 32'h3);
    rdc(`STATUS_ADDR, 32'h3);
    put(15'h0200);
    rdc(`STATUS_ADDR, 32'h2);
    put(15'h0000);
    rdc(`STATUS_ADDR, 32'h0);
    // event bits, mask and the interrupt line
    chk(irq_r, 32'h0);
    rdc(`EVENT_ADDR, 32'h7F);
    rdc(`EVENT_ADDR, 32'h0);
    xfer(1'b1, `MASK_ADDR, 32'h40);
    chk(er, 32'h0);
    rdc(`MASK_ADDR, 32'h40);
    put(15'h0100);
    chk(irq_r, 32'h0);
    put(15'h4000);
    // the line is registered after the event bit, one more edge
    @(posedge clock);
    chk(irq_r, 32'h1);
    rdc(`EVENT_ADDR, 32'h41);
    repeat (2) @(posedge clock);
    chk(irq_r, 32'h0);
    // unmapped place refuses
    xfer(1'b1, 16'hE300, 32'hFFFFFFFF);
    chk(er, 32'h1);
    rdc(16'hE300, 32'h0);
    chk(er, 32'h1);
    // arbitration among enabled wan sources
    xfer(1'b1, `WAN_EN_ADDR, 32'h7F);
    xfer(1'b1, `PRIO_ADDR, 32'h0123456F);
    put(15'h007F);
    chk_arb(ARB_NORMAL, 3'h0, 4'hF);
    xfer(1'b1, `WAN_EN_ADDR, 32'h7E);
    repeat (3) @(posedge clock);
    chk_arb(ARB_NORMAL, 3'h1, 4'h6);
    rdc(`WAN_EN_ADDR, 32'h7E);
    put(15'h00FF);
    chk(arb_state_r, ARB_FAST);
    put(15'h0040);
    chk_arb(ARB_NORMAL, 3'h6, 4'h1);
    rdc(`ARB_ADDR, 32'h261);
    put(15'h0000);
    chk(arb_state_r, ARB_NONE);
    close_out;
  end
endmodule : tb_irq_status_and_wan_priority
